// file: psram_bus_defs.svh
// Purpose: shared constants of the pseudo-static memory host bus interface
// Assumes: core clock of 125 MHz, 16-bit data, 22-bit word address
// Notes: field positions of the two configuration registers live here
//
// Notes on behaviour
// - hold off for the init time after power
// - init loads both configuration registers with defaults
// - start asynchronous; bus config then picks the mode
// - async read: select, output and byte enables low
// - async write: select, write, byte low; output ignored
// - write data caught at first control rising edge
// - bus clock low in async; wait driven, ignored
// - low four bits pick page word; above restart
// - page mode enable bit; host keeps strobe low
// - burst address and direction taken at first edge
// - burst length 4/8/16/32 or continuous row
// - latency count sets first transfer; read latency type
// - fixed latency includes worst refresh collision allowance
// - wait during latency and at row crossing
// - suspend by stopping clock; wait stays driven
// - async accesses accepted in burst mode between bursts
// - mode bit selects asynchronous or burst
// - latency type bit: variable or fixed
// - low byte enable gates low lane, high high
// - wait polarity bit
`ifndef PSRAM_BUS_DEFS_SVH
`define PSRAM_BUS_DEFS_SVH

`define ADDR_W 22
`define DQ_W 16
`define CLK_PERIOD_NS 8
`define INIT_TIME_US 150
`define INIT_CNT_W 20
`define RANDOM_ACCESS_TIME_NS 64
`define PAGE_ACCESS_TIME_NS 24
`define PAGE_BITS 4
`define ROW_BITS 7

`define BCR_MODE_BIT 15
`define BCR_LATTYPE_BIT 14
`define BCR_LAT_HI 13
`define BCR_LAT_LO 11
`define BCR_WAITPOL_BIT 10
`define BCR_NOWRAP_BIT 3
`define BCR_LEN_HI 2
`define BCR_LEN_LO 0
`define RCR_PAGE_BIT 7

`define BCR_RESET 16'h9C0F
`define RCR_RESET 16'h0010

`define LEN_4 3'h1
`define LEN_8 3'h2
`define LEN_16 3'h3
`define LEN_32 3'h4
`define MASK_4 5'h03
`define MASK_8 5'h07
`define MASK_16 5'h0F
`define MASK_32 5'h1F

`endif

// file: psram_bus_pkg.sv
// Purpose: state types of the memory host bus interface
// Assumes: constants from the shared header
// Notes: one struct per clock domain
`include "psram_bus_defs.svh"
package psram_bus_pkg;

  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic lbN;
    logic ubN;
    logic advN;
    logic [`ADDR_W-1:0] addr;
    logic [`DQ_W-1:0] dq;
  } pins_t;

  typedef enum logic [3:0] {
    LK_IDLE = 4'h1,
    LK_LAT = 4'h2,
    LK_DATA = 4'h4,
    LK_ROW = 4'h8
  } link_fsm_t;

  typedef struct packed {
    logic [`INIT_CNT_W-1:0] initCnt;
    logic ready;
    logic [15:0] bus_config_reg;
    logic [15:0] refresh_config_reg;
    pins_t p1;
    pins_t p2;
    pins_t p3;
    logic [1:0] ws;
    logic [1:0] bs;
    logic [1:0] ds;
    logic [2:0] rt;
    logic [2:0] wt;
    logic [`ADDR_W-1:0] accAddr;
    logic [3:0] accCnt;
    logic accValid;
    logic rdPrev;
    logic wrAct;
    logic memWe;
    logic [1:0] memBe;
    logic [`ADDR_W-1:0] memAddr;
    logic [`DQ_W-1:0] memData;
    logic [`DQ_W-1:0] dqOut;
    logic [1:0] dqOe;
    logic waitOut;
    logic waitOe;
  } clk_state_t;

  typedef struct packed {
    logic [1:0] rs;
    logic [15:0] cb1;
    logic [15:0] cb2;
    logic [1:0] rb;
    link_fsm_t state;
    logic isWrite;
    logic [`ADDR_W-1:0] addr;
    logic [3:0] latCnt;
    logic [4:0] wordCnt;
    logic waitLvl;
    logic busy;
    logic [`DQ_W-1:0] rdWord;
    logic rdTgl;
    logic [`ADDR_W-1:0] wrAddr;
    logic [`DQ_W-1:0] wrData;
    logic [1:0] wrBe;
    logic wrTgl;
  } link_state_t;

endpackage

// file: psram_word_mem.sv
// Purpose: word array with byte-lane writes and two read ports
// Assumes: single writer in the core clock domain
// Notes: read ports are combinational; one per clock domain
`timescale 1ns/10ps
module psram_word_mem #(
  parameter int AW = 22,
  parameter int DW = 16
)(
  input wire logic wrClk,
  input wire logic we,
  input wire logic [DW/8-1:0] be,
  input wire logic [AW-1:0] wAddr,
  input wire logic [DW-1:0] wData,
  input wire logic [AW-1:0] rdAddrA,
  output logic [DW-1:0] rdDataA,
  input wire logic [AW-1:0] rdAddrB,
  output logic [DW-1:0] rdDataB
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  if (DW % 8 != 0) begin : g_bad_dw
    $error("data width must be whole bytes");
  end

  // disabled lanes keep their stored value
  always_ff @(posedge wrClk) begin
    for (int i = 0; i < DW/8; i++) begin
      if (we && be[i]) begin
        mem[wAddr][i*8 +: 8] <= wData[i*8 +: 8];
      end
    end
  end

  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];
endmodule

// file: psram_bus_dev.sv
// Purpose: device side of a pseudo-static memory host bus
// Assumes: burstClk is the host bus clock, stopped outside bursts
// Notes: all pins are driven from the core clock domain
`timescale 1ns/10ps
`include "psram_bus_defs.svh"
module psram_bus_dev #(
  parameter int MEM_AW = `ADDR_W,
  parameter int INIT_CYCLES = `INIT_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int RANDOM_ACCESS_NS = `RANDOM_ACCESS_TIME_NS,
  parameter int PAGE_ACCESS_NS = `PAGE_ACCESS_TIME_NS
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic burstClk,
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic wrEnN,
  input wire logic lowByteSelN,
  input wire logic highByteSelN,
  input wire logic addrValidN,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DQ_W-1:0] dqIn,
  output logic [`DQ_W-1:0] dqOut,
  output logic [1:0] dqOe,
  output logic waitOut,
  output logic waitOe,
  input wire logic cfgLoad,
  input wire logic cfgSelBus,
  input wire logic [15:0] cfgValue,
  input wire logic refreshBusy,
  output logic ready,
  output logic [15:0] busConfigReg,
  output logic [15:0] refreshConfigReg
);
  // ****************************************
  // timing and checks
  // ****************************************
  localparam int RAND_CYC_I = (RANDOM_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int PAGE_CYC_I = (PAGE_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [3:0] RAND_CYC = 4'(RAND_CYC_I);
  localparam logic [3:0] PAGE_CYC = 4'(PAGE_CYC_I);
  localparam logic [`INIT_CNT_W-1:0] INIT_LAST = `INIT_CNT_W'(INIT_CYCLES - 1);

  if (MEM_AW < `ROW_BITS + 1 || MEM_AW > `ADDR_W) begin : g_bad_aw
    $error("memory address width out of range");
  end
  if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << `INIT_CNT_W)) begin : g_bad_init
    $error("init cycle count does not fit the counter");
  end
  if (RAND_CYC_I < 1 || RAND_CYC_I > 15 || PAGE_CYC_I < 1 || PAGE_CYC_I > 15)
  begin : g_bad_acc
    $error("access cycle counts must lie in 1 to 15");
  end

  // ****************************************
  // state
  // ****************************************
  psram_bus_pkg::clk_state_t cs_r;
  psram_bus_pkg::clk_state_t cs_nxt;
  psram_bus_pkg::link_state_t lk_r;
  psram_bus_pkg::link_state_t lk_nxt;
  psram_bus_pkg::pins_t pinsNow;
  logic [`DQ_W-1:0] rdDataA;
  logic [`DQ_W-1:0] rdDataB;
  logic [`ADDR_W-1:0] linkRdAddr;
  logic [`ADDR_W-1:0] nextAddr;

  assign pinsNow = {chipSelN, outEnN, wrEnN, lowByteSelN, highByteSelN, addrValidN,
                    addr, dqIn};

  psram_word_mem #(
    .AW(MEM_AW),
    .DW(`DQ_W)
  ) u_mem (
    .wrClk(clk),
    .we(cs_r.memWe),
    .be(cs_r.memBe),
    .wAddr(cs_r.memAddr[MEM_AW-1:0]),
    .wData(cs_r.memData),
    .rdAddrA(cs_r.accAddr[MEM_AW-1:0]),
    .rdDataA(rdDataA),
    .rdAddrB(linkRdAddr[MEM_AW-1:0]),
    .rdDataB(rdDataB)
  );

  // ****************************************
  // core clock domain
  // ****************************************
  always_comb begin
    logic burstAct;
    logic asyncOk;
    logic rdSel;
    logic wrNow;
    logic pageHit;
    logic burstRdOe;
    logic waitAct;
    logic [`ADDR_W-1:0] addrNow;
    burstAct = 1'b0;
    asyncOk = 1'b0;
    rdSel = 1'b0;
    wrNow = 1'b0;
    pageHit = 1'b0;
    burstRdOe = 1'b0;
    waitAct = 1'b1;
    addrNow = '0;
    cs_nxt = cs_r;
    // pins and link levels cross through two stages before use
    cs_nxt.p1 = pinsNow;
    cs_nxt.p2 = cs_r.p1;
    cs_nxt.p3 = cs_r.p2;
    cs_nxt.ws = {cs_r.ws[0], lk_r.waitLvl};
    cs_nxt.bs = {cs_r.bs[0], lk_r.busy};
    cs_nxt.ds = {cs_r.ds[0], ~lk_r.isWrite};
    cs_nxt.rt = {cs_r.rt[1:0], lk_r.rdTgl};
    cs_nxt.wt = {cs_r.wt[1:0], lk_r.wrTgl};

    // self-initialisation: the bus stays ignored until the count expires
    if (!cs_r.ready) begin
      if (cs_r.initCnt == INIT_LAST) begin
        cs_nxt.ready = 1'b1;
      end else begin
        cs_nxt.initCnt = cs_r.initCnt + 1'b1;
      end
    end

    // configuration only changes while the device is deselected
    if (cfgLoad && cs_r.p2.ceN && cs_r.ready) begin
      if (cfgSelBus) begin
        cs_nxt.bus_config_reg = cfgValue;
      end else begin
        cs_nxt.refresh_config_reg = cfgValue;
      end
    end

    burstAct = !cs_r.bus_config_reg[`BCR_MODE_BIT] && cs_r.bs[1] && !cs_r.p2.ceN;
    asyncOk = cs_r.ready && !burstAct;
    addrNow = cs_r.p2.advN ? cs_r.accAddr : cs_r.p2.addr;
    cs_nxt.accAddr = addrNow;

    // asynchronous read with optional page hits
    rdSel = asyncOk && !cs_r.p2.ceN && !cs_r.p2.oeN && cs_r.p2.weN &&
            !(cs_r.p2.lbN && cs_r.p2.ubN);
    cs_nxt.rdPrev = rdSel;
    if (!rdSel) begin
      cs_nxt.accValid = 1'b0;
      cs_nxt.accCnt = 4'h0;
    end else if (!cs_r.rdPrev || addrNow != cs_r.accAddr) begin
      pageHit = cs_r.refresh_config_reg[`RCR_PAGE_BIT] && cs_r.accValid &&
                addrNow[`ADDR_W-1:`PAGE_BITS] == cs_r.accAddr[`ADDR_W-1:`PAGE_BITS];
      cs_nxt.accCnt = pageHit ? PAGE_CYC : RAND_CYC;
      cs_nxt.accValid = pageHit;
    end else if (cs_r.accCnt != 4'h0) begin
      cs_nxt.accCnt = cs_r.accCnt - 4'h1;
      if (cs_r.accCnt == 4'h1) begin
        cs_nxt.dqOut = rdDataA;
        cs_nxt.accValid = 1'b1;
      end
    end

    // burst read words arrive with a toggle; the word is stable by then
    if (cs_r.rt[2] != cs_r.rt[1]) begin
      cs_nxt.dqOut = lk_r.rdWord;
    end
    burstRdOe = burstAct && cs_r.ds[1] && !cs_r.p2.oeN;
    cs_nxt.dqOe = (rdSel || burstRdOe) ? ~{cs_r.p2.ubN, cs_r.p2.lbN} : 2'b00;

    // asynchronous write: output enable is ignored while write enable is low
    wrNow = asyncOk && !cs_r.p2.ceN && !cs_r.p2.weN &&
            !(cs_r.p2.lbN && cs_r.p2.ubN);
    cs_nxt.wrAct = wrNow;
    cs_nxt.memWe = 1'b0;
    if (cs_r.wt[2] != cs_r.wt[1]) begin
      cs_nxt.memWe = 1'b1;
      cs_nxt.memAddr = lk_r.wrAddr;
      cs_nxt.memBe = lk_r.wrBe;
      cs_nxt.memData = lk_r.wrData;
    end else if (cs_r.wrAct && !wrNow) begin
      // the last sample before the first rising control holds the data
      cs_nxt.memWe = 1'b1;
      cs_nxt.memAddr = cs_r.accAddr;
      cs_nxt.memBe = ~{cs_r.p3.ubN, cs_r.p3.lbN};
      cs_nxt.memData = cs_r.p3.dq;
    end

    // wait is driven while selected, asserted outside burst data phases
    waitAct = burstAct ? cs_r.ws[1] : 1'b1;
    cs_nxt.waitOut = cs_r.bus_config_reg[`BCR_WAITPOL_BIT] ? waitAct : !waitAct;
    cs_nxt.waitOe = cs_r.ready && !cs_r.p2.ceN;

    if (reset) begin
      cs_nxt = '0;
      cs_nxt.bus_config_reg = `BCR_RESET;
      cs_nxt.refresh_config_reg = `RCR_RESET;
    end
  end

  always_ff @(posedge clk) begin
    cs_r <= cs_nxt;
  end

  // ****************************************
  // burst clock domain
  // ****************************************
  always_comb begin
    logic [15:0] bus_config_reg;
    logic [4:0] lenMask;
    logic contBurst;
    logic wrapOn;
    logic hold;
    logic [4:0] low5;
    bus_config_reg = lk_r.cb2;
    lenMask = `MASK_32;
    contBurst = 1'b0;
    unique case (bus_config_reg[`BCR_LEN_HI:`BCR_LEN_LO])
      `LEN_4: lenMask = `MASK_4;
      `LEN_8: lenMask = `MASK_8;
      `LEN_16: lenMask = `MASK_16;
      `LEN_32: lenMask = `MASK_32;
      default: contBurst = 1'b1;
    endcase
    wrapOn = !bus_config_reg[`BCR_NOWRAP_BIT] && !contBurst;
    low5 = lk_r.addr[4:0] + 5'h01;
    nextAddr = wrapOn ?
               {lk_r.addr[`ADDR_W-1:5], (lk_r.addr[4:0] & ~lenMask) | (low5 & lenMask)} :
               lk_r.addr + 1'b1;
    linkRdAddr = (lk_r.state == psram_bus_pkg::LK_DATA) ? nextAddr : lk_r.addr;
    hold = !bus_config_reg[`BCR_LATTYPE_BIT] && !lk_r.isWrite && lk_r.rb[1];

    lk_nxt = lk_r;
    lk_nxt.rs = {lk_r.rs[0], reset};
    lk_nxt.cb1 = cs_r.bus_config_reg;
    lk_nxt.cb2 = lk_r.cb1;
    lk_nxt.rb = {lk_r.rb[0], refreshBusy};

    if (!chipSelN && !addrValidN && !bus_config_reg[`BCR_MODE_BIT]) begin
      lk_nxt.state = psram_bus_pkg::LK_LAT;
      lk_nxt.isWrite = !wrEnN;
      lk_nxt.addr = addr;
      lk_nxt.latCnt = 4'({1'b0, bus_config_reg[`BCR_LAT_HI:`BCR_LAT_LO]}) + 4'h1;
      lk_nxt.wordCnt = 5'h00;
      lk_nxt.waitLvl = 1'b1;
      lk_nxt.busy = 1'b1;
    end else if (!chipSelN) begin
      unique case (lk_r.state)
        psram_bus_pkg::LK_IDLE: begin
          lk_nxt.waitLvl = 1'b1;
        end
        psram_bus_pkg::LK_LAT: begin
          // fixed latency ignores refresh: the count already covers it
          if (hold) begin
            lk_nxt.waitLvl = 1'b1;
          end else if (lk_r.latCnt == 4'h1) begin
            lk_nxt.state = psram_bus_pkg::LK_DATA;
            lk_nxt.waitLvl = 1'b0;
            if (!lk_r.isWrite) begin
              lk_nxt.rdWord = rdDataB;
              lk_nxt.rdTgl = !lk_r.rdTgl;
            end
          end else begin
            lk_nxt.latCnt = lk_r.latCnt - 4'h1;
          end
        end
        psram_bus_pkg::LK_DATA: begin
          if (lk_r.isWrite) begin
            lk_nxt.wrAddr = lk_r.addr;
            lk_nxt.wrData = dqIn;
            lk_nxt.wrBe = ~{highByteSelN, lowByteSelN};
            lk_nxt.wrTgl = !lk_r.wrTgl;
          end
          lk_nxt.addr = nextAddr;
          lk_nxt.wordCnt = lk_r.wordCnt + 5'h01;
          if (!contBurst && !wrapOn && lk_r.wordCnt == lenMask) begin
            lk_nxt.state = psram_bus_pkg::LK_IDLE;
            lk_nxt.busy = 1'b0;
            lk_nxt.waitLvl = 1'b1;
          end else if (!wrapOn && nextAddr[`ROW_BITS-1:0] == '0) begin
            lk_nxt.state = psram_bus_pkg::LK_ROW;
            lk_nxt.waitLvl = 1'b1;
          end else if (!lk_r.isWrite) begin
            lk_nxt.rdWord = rdDataB;
            lk_nxt.rdTgl = !lk_r.rdTgl;
          end
        end
        psram_bus_pkg::LK_ROW: begin
          // one extra clock to open the next row
          lk_nxt.state = psram_bus_pkg::LK_DATA;
          lk_nxt.waitLvl = 1'b0;
          if (!lk_r.isWrite) begin
            lk_nxt.rdWord = rdDataB;
            lk_nxt.rdTgl = !lk_r.rdTgl;
          end
        end
      endcase
    end

    if (lk_r.rs[1]) begin
      lk_nxt.state = psram_bus_pkg::LK_IDLE;
      lk_nxt.busy = 1'b0;
      lk_nxt.waitLvl = 1'b1;
      lk_nxt.rdTgl = 1'b0;
      lk_nxt.wrTgl = 1'b0;
      lk_nxt.isWrite = 1'b0;
    end
  end

  // a stopped clock simply freezes the burst: suspend needs no logic
  always_ff @(posedge burstClk) begin
    lk_r <= lk_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dqOut = cs_r.dqOut;
  assign dqOe = cs_r.dqOe;
  assign waitOut = cs_r.waitOut;
  assign waitOe = cs_r.waitOe;
  assign ready = cs_r.ready;
  assign busConfigReg = cs_r.bus_config_reg;
  assign refreshConfigReg = cs_r.refresh_config_reg;
endmodule

// file: psram_bus_dev_sva.sv
// Purpose: property checker for the memory host bus device
// Assumes: core clock domain only; pins are sampled raw, two flops before use
// Notes: pin-to-output relations allow for the three-clock sampling delay
`timescale 1ns/10ps
// ****************
// checker
// ****************
module psram_bus_dev_sva #(
  parameter int INIT_CYCLES = 20
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic wrEnN,
  input wire logic lowByteSelN,
  input wire logic highByteSelN,
  input wire logic [1:0] dqOe,
  input wire logic waitOe,
  input wire logic cfgLoad,
  input wire logic cfgSelBus,
  input wire logic [15:0] cfgValue,
  input wire logic ready,
  input wire logic [15:0] busConfigReg,
  input wire logic [15:0] refreshConfigReg
);
  logic [15:0] upCnt_r;
  // counts edges since reset release until ready
  always_ff @(posedge clk) begin
    if (reset || ready) begin
      upCnt_r <= 16'h0000;
    end else begin
      upCnt_r <= upCnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ready_delay: assert property (
    $rose(ready) |-> upCnt_r >= INIT_CYCLES - 2 && upCnt_r <= INIT_CYCLES + 2)
    else $error("ready rose at the wrong time");
  a_cfg_default: assert property (
    !ready && $past(reset) |-> busConfigReg == 16'h9C0F && refreshConfigReg == 16'h0010)
    else $error("config registers not at defaults");
  a_quiet_init: assert property (
    !ready |-> dqOe == 2'h0 && !waitOe) else $error("pins driven before ready");
  a_wait_driven: assert property (
    (ready && !chipSelN)[*4] |=> waitOe) else $error("wait not driven while selected");
  a_wait_released: assert property (
    chipSelN[*4] |=> !waitOe) else $error("wait driven while deselected");
  a_read_drives: assert property (
    (ready && busConfigReg[15] && !chipSelN && !outEnN && wrEnN && !lowByteSelN
      && !highByteSelN)[*4] |=> dqOe == 2'h3) else $error("async read not driven");
  a_write_quiet: assert property (
    (!chipSelN && !wrEnN)[*4] |=> dqOe == 2'h0) else $error("data driven during write");
  a_low_lane: assert property (
    lowByteSelN[*4] |=> !dqOe[0]) else $error("low lane driven while disabled");
  a_high_lane: assert property (
    highByteSelN[*4] |=> !dqOe[1]) else $error("high lane driven while disabled");
  a_bus_load: assert property (
    chipSelN[*4] ##0 (ready && cfgLoad && cfgSelBus) |-> ##[1:2] busConfigReg == cfgValue)
    else $error("bus config not loaded");
  a_ref_load: assert property (
    chipSelN[*4] ##0 (ready && cfgLoad && !cfgSelBus) |-> ##[1:2] refreshConfigReg == cfgValue)
    else $error("refresh config not loaded");
endmodule
bind psram_bus_dev psram_bus_dev_sva #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.clk(clk),
  .reset(reset), .chipSelN(chipSelN), .outEnN(outEnN), .wrEnN(wrEnN),
  .lowByteSelN(lowByteSelN), .highByteSelN(highByteSelN), .dqOe(dqOe), .waitOe(waitOe),
  .cfgLoad(cfgLoad), .cfgSelBus(cfgSelBus), .cfgValue(cfgValue), .ready(ready),
  .busConfigReg(busConfigReg), .refreshConfigReg(refreshConfigReg));

// file: psram_host_model.sv
// Purpose: memory controller model driving the host bus pins
// Assumes: bus clock of 80 ns, made inside burst frames and for three edges at start to apply reset
// Notes: released data lines show the inverse of the last value
`timescale 1ns/10ps
`include "psram_bus_defs.svh"
// ****************
// host model
// ****************
module psram_host_model (
  input wire logic clk,
  input wire logic [`DQ_W-1:0] dqOut,
  input wire logic waitOut,
  output logic burstClk,
  output logic chipSelN,
  output logic outEnN,
  output logic wrEnN,
  output logic lowByteSelN,
  output logic highByteSelN,
  output logic addrValidN,
  output logic [`ADDR_W-1:0] addr,
  output logic [`DQ_W-1:0] dqIn
);
  initial begin
    {chipSelN, outEnN, wrEnN, lowByteSelN, highByteSelN} = 5'h1F;
    addrValidN = 1'b0;
    addr = 22'h000000;
    dqIn = 16'h0000;
    burstClk = 1'b0;
    // three edges: the link side takes two to sync reset and one to apply it
    repeat (3) begin
      #38 burstClk = 1'b1;
      #40 burstClk = 1'b0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic write(input logic [`ADDR_W-1:0] a, input logic [15:0] d,
      input logic [1:0] laneN);
    cyc(1);
    addr = a;
    dqIn = d;
    outEnN = 1'b0;
    {highByteSelN, lowByteSelN} = laneN;
    wrEnN = 1'b0;
    chipSelN = 1'b0;
    cyc(5);
    {chipSelN, wrEnN, outEnN, highByteSelN, lowByteSelN} = 5'h1F;
    cyc(1);
    dqIn = ~d;
    cyc(5);
  endtask
  task automatic read2(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] b,
      output logic [15:0] d0, output logic [15:0] d1);
    cyc(1);
    addr = a;
    {chipSelN, outEnN, highByteSelN, lowByteSelN} = 4'h0;
    cyc(14);
    d0 = dqOut;
    addr = b;
    // sampled before a full random access could finish
    cyc(7);
    d1 = dqOut;
    {chipSelN, outEnN, highByteSelN, lowByteSelN} = 4'hF;
    cyc(5);
  endtask
  task automatic burst(input logic wr, input logic [`ADDR_W-1:0] a, input int lat,
      input logic [63:0] wd, output logic [63:0] rd, output logic [1:0] wt);
    int k;
    rd = 64'h0;
    // keeps bus clock edges clear of core clock edges
    #5;
    for (k = -2; k < lat + 6; k++) begin
      if (k == lat) wt[0] = waitOut;
      if (k == lat + 3) wt[1] = waitOut;
      if (k >= lat + 2) rd[16*(k-lat-2) +: 16] = dqOut;
      burstClk = 1'b1;
      #1;
      if (k == -1) begin
        addr = a;
        {highByteSelN, lowByteSelN} = 2'h0;
        wrEnN = ~wr;
        outEnN = wr;
        chipSelN = 1'b0;
      end
      if (k == 0) addrValidN = 1'b1;
      if (wr && k > lat && k < lat + 5) dqIn = wd[16*(k-lat-1) +: 16];
      // deselect right after the last word so no async write follows the burst
      if (k == lat + 5) {chipSelN, outEnN, wrEnN, highByteSelN, lowByteSelN} = 5'h1F;
      #39 burstClk = 1'b0;
      #40;
    end
    {chipSelN, outEnN, wrEnN, highByteSelN, lowByteSelN} = 5'h1F;
    addrValidN = 1'b0;
    dqIn = ~dqIn;
    cyc(6);
  endtask
endmodule

// file: test_psram_async_page_burst_bus.sv
// Purpose: self-checking bench for the memory host bus device
// Assumes: short init count and small array for a quick run
// Notes: latency code 3, fixed or variable, and length 4 without wrap for bursts
`timescale 1ns/10ps
`include "psram_bus_defs.svh"
// ****************
// bench
// ****************
module test_psram_async_page_burst_bus;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfgLoad = 1'b0;
  logic cfgSelBus = 1'b0;
  logic [15:0] cfgValue = 16'h0000;
  logic refreshBusy = 1'b0;
  wire logic burstClk, chipSelN, outEnN, wrEnN, lowByteSelN, highByteSelN, addrValidN;
  wire logic [`ADDR_W-1:0] addr;
  wire logic [`DQ_W-1:0] dqIn;
  logic [`DQ_W-1:0] dqOut;
  logic [1:0] dqOe;
  logic waitOut, waitOe, ready;
  logic [15:0] busConfigReg, refreshConfigReg, d0, d1;
  logic [63:0] rd;
  logic [1:0] wt;
  int nFail = 0;
  int cmpCount = 0;
  int i;
  always #4 clk = ~clk;
  psram_host_model host_u (.clk(clk), .dqOut(dqOut), .waitOut(waitOut), .burstClk(burstClk),
    .chipSelN(chipSelN), .outEnN(outEnN), .wrEnN(wrEnN), .lowByteSelN(lowByteSelN),
    .highByteSelN(highByteSelN), .addrValidN(addrValidN), .addr(addr), .dqIn(dqIn));
  psram_bus_dev #(.MEM_AW(10), .INIT_CYCLES(20)) dut_u (.clk(clk), .reset(reset),
    .burstClk(burstClk), .chipSelN(chipSelN), .outEnN(outEnN), .wrEnN(wrEnN),
    .lowByteSelN(lowByteSelN), .highByteSelN(highByteSelN), .addrValidN(addrValidN),
    .addr(addr), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .waitOut(waitOut), .waitOe(waitOe),
    .cfgLoad(cfgLoad), .cfgSelBus(cfgSelBus), .cfgValue(cfgValue), .refreshBusy(refreshBusy),
    .ready(ready), .busConfigReg(busConfigReg), .refreshConfigReg(refreshConfigReg));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (nFail == 0 && cmpCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // loads only while deselected; value held afterwards
  task automatic cfg(input logic sel, input logic [15:0] v);
    @(posedge clk);
    #1;
    cfgSelBus = sel;
    cfgValue = v;
    cfgLoad = 1'b1;
    @(posedge clk);
    #1;
    cfgLoad = 1'b0;
    @(posedge clk);
    #1;
  endtask
  initial begin
    #40000;
    nFail++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    check("busDefault", busConfigReg, 16'h9C0F);
    check("refDefault", refreshConfigReg, 16'h0010);
    check("readyEarly", 64'(ready), 64'h0);
    for (i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk);
    check("readyLate", 64'(ready), 64'h1);
    host_u.write(22'h000005, 16'h1234, 2'b00);
    host_u.write(22'h000005, 16'hCDEF, 2'b10);
    host_u.write(22'h000006, 16'h5A5A, 2'b00);
    host_u.write(22'h000015, 16'h0F0F, 2'b00);
    host_u.read2(22'h000005, 22'h000006, d0, d1);
    check("asyncRead", d0, 16'h12EF);
    check("pageOff", d1, 16'h12EF);
    cfg(1'b0, 16'h0090);
    check("pageCfg", refreshConfigReg, 16'h0090);
    host_u.read2(22'h000005, 22'h000006, d0, d1);
    check("pageHit", d1, 16'h5A5A);
    host_u.read2(22'h000006, 22'h000015, d0, d1);
    check("pageMiss", d1, 16'h5A5A);
    cfg(1'b1, 16'h5C09);
    check("burstCfg", busConfigReg, 16'h5C09);
    host_u.burst(1'b1, 22'h000020, 3, 64'h4444_3333_2222_1111, rd, wt);
    cfg(1'b1, 16'h5C09);
    refreshBusy = 1'b1;
    host_u.burst(1'b0, 22'h000020, 3, 64'h0, rd, wt);
    check("burstRead", rd, 64'h4444_3333_2222_1111);
    check("waitFixed", wt, 2'b01);
    cfg(1'b1, 16'h1C09);
    host_u.burst(1'b0, 22'h000020, 3, 64'h0, rd, wt);
    check("waitRefresh", wt, 2'b11);
    refreshBusy = 1'b0;
    host_u.burst(1'b0, 22'h000020, 3, 64'h0, rd, wt);
    check("varRead", rd, 64'h4444_3333_2222_1111);
    check("varWait", wt, 2'b01);
    cfg(1'b1, 16'h5809);
    host_u.burst(1'b0, 22'h000020, 3, 64'h0, rd, wt);
    check("waitLow", wt, 2'b10);
    host_u.write(22'h000023, 16'h7777, 2'b00);
    host_u.read2(22'h000022, 22'h000022, d0, d1);
    check("mixedRead", d0, 16'h3333);
    host_u.read2(22'h000023, 22'h000023, d0, d1);
    check("mixedWrite", d0, 16'h7777);
    summarize();
  end
endmodule
